// >>> rtl/spl_fifo.sv
// Parameterised valid/ready FIFO for outgoing characters.
`timescale 1ns/100ps
module spl_fifo #(
	parameter int WIDTH = 7,
	parameter int DEPTH = 16
) (
	input wire logic clk, // Clock.
	input wire logic rst, // Asynchronous reset.
	input wire logic ce, // Clock enable.
	input wire logic in_valid, // Write request.
	output logic in_ready, // Not full.
	input wire logic [WIDTH-1:0] in_data, // Write data.
	output logic out_valid, // Not empty.
	input wire logic out_ready, // Read request.
	output logic [WIDTH-1:0] out_data // Head word.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic wr;
	logic rd;

	assign in_ready = (cnt != (AW+1)'(DEPTH));
	assign out_valid = (cnt != '0);
	assign out_data = mem[rp];
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (ce && wr) begin
			mem[wp] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else if (ce) begin
			if (wr) begin
				wp <= wp + 1'b1;
			end
			if (rd) begin
				rp <= rp + 1'b1;
			end
			cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

// >>> rtl/spl_pkg.sv
// Package of constants and types for the serial parameter link slave.
package spl_pkg;

	// ----------------------------------------
	// Control and value text characters
	// ----------------------------------------
	localparam logic [6:0] CH_STX = 7'h02;
	localparam logic [6:0] CH_ETX = 7'h03;
	localparam logic [6:0] CH_EOT = 7'h04;
	localparam logic [6:0] CH_ENQ = 7'h05;
	localparam logic [6:0] CH_ACK = 7'h06;
	localparam logic [6:0] CH_NAK = 7'h15;
	localparam logic [6:0] CH_DOT = 7'h2E;
	localparam logic [6:0] CH_ZERO = 7'h30;
	localparam logic [6:0] CH_MINUS = 7'h2D;

	// ----------------------------------------
	// Sizes and timing
	// ----------------------------------------
	localparam int ADDR_CHARS = 4;
	localparam int VAL_MAX = 12;
	localparam int VAL_IDX_W = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 7;
	localparam int CLK_MHZ = 125;
	localparam int MASTER_TIMEOUT_MS = 160;
	localparam logic [2:0] GROUP_MAX = 3'h7;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [6:0] data;
		logic parity_err;
	} spl_rx_char_s;

	typedef struct packed {
		logic [6:0] code_hi;
		logic [6:0] code_lo;
	} spl_code_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_CMD = 4'h3,
		ST_CODE2 = 4'h2,
		ST_ENQ = 4'h6,
		ST_LOOK = 4'h7,
		ST_SEND = 4'h5,
		ST_WAIT = 4'h4,
		ST_WCODE1 = 4'hC,
		ST_WCODE2 = 4'hD,
		ST_WDATA = 4'hF,
		ST_WBCC = 4'hE,
		ST_WCHK = 4'hA,
		ST_DEAF = 4'hB
	} spl_state_e;

endpackage

// >>> rtl/spl_slave.sv
// Character-level slave engine for the multidrop serial parameter link.
`timescale 1ns/100ps
// How it works
// [RULE_01] EOT resets link; next four chars are address.
// [RULE_02] Read: EOT, GG, UU, code, ENQ.
// [RULE_03] Group then unit digit, each sent twice.
// [RULE_04] Reply STX, code, value, ETX, BCC.
// [RULE_05] Shortest value text, no trailing zeros.
// [RULE_06] BCC is XOR after STX through ETX.
// [RULE_07] Master verifies BCC before trusting reply.
// [RULE_08] Unknown code on read answers single EOT.
// [RULE_09] NAK after reply resends same parameter.
// [RULE_10] ACK after reply sends next list parameter.
// [RULE_11] Master ends session with EOT.
// [RULE_12] Silent read on mismatch, parity, or disabled.
// [RULE_13] Master waits 160 ms before retrying.
// [RULE_14] Write: address then STX, code, value, ETX, BCC.
// [RULE_15] Master computes BCC over code through ETX.
// [RULE_16] Write checks all pass: update, send ACK.
// [RULE_17] Any failed write check sends NAK, discards.
// [RULE_18] Master may resend data part after NAK.
// [RULE_19] Silent write on mismatch, parity, or disabled.
// [RULE_20] Binary frame: start, 7 data, control, parity.
// [RULE_21] Binary frame ends one stop; control marks data.
// [RULE_22] Text frame: start, seven bits, parity, stop.
// [RULE_23] Group 0 to 7, unit 0 to F.
// [RULE_24] Unmatched slave ignores all until next EOT.
// [RULE_25] Continuations honoured only while connected.
module spl_slave #(
	parameter int VAL_W = spl_pkg::VAL_MAX
) (
	input wire logic clk, // Clock, 125 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic ce, // Clock enable; low freezes all state.
	input wire logic serial_link_enable, // Link enable from configuration.
	input wire logic [2:0] group_address_digit, // Own group digit.
	input wire logic [3:0] unit_address_digit, // Own unit digit.
	input wire logic rx_valid, // Received character strobe from the UART.
	input wire spl_pkg::spl_rx_char_s rx_char, // Received character and parity flag.
	output spl_pkg::spl_code_s prm_code, // Parameter code being accessed.
	output logic prm_rd_req, // Read lookup pulse for prm_code.
	output logic prm_next_req, // Advance to next list entry pulse.
	input wire logic prm_known, // Code readable, valid with prm_text.
	input wire logic [VAL_W*7-1:0] prm_text, // Value text, first char in low bits.
	input wire logic [spl_pkg::VAL_IDX_W-1:0] prm_len, // Raw text length.
	input wire spl_pkg::spl_code_s prm_next_code, // Code of the next list entry.
	output logic prm_wr_req, // Write check pulse.
	output logic [VAL_W*7-1:0] prm_wr_text, // Received value text.
	output logic [spl_pkg::VAL_IDX_W-1:0] prm_wr_len, // Received value length.
	input wire logic prm_wr_ok, // Writable and in range; answered one cycle after prm_wr_req.
	output logic tx_valid, // Character ready for the UART.
	input wire logic tx_ready, // UART accepts a character.
	output logic [6:0] tx_data, // Character to send.
	output logic connected // Connection established with this slave.
);
	import spl_pkg::*;

	// ----------------------------------------
	// State and storage
	// ----------------------------------------
	spl_state_e st;
	logic [2:0] acnt;
	logic [6:0] abuf [ADDR_CHARS];
	logic [VAL_IDX_W-1:0] tlen;
	logic [VAL_IDX_W-1:0] tpos;
	logic [6:0] bcc;
	logic [6:0] rbcc;
	logic [VAL_W*7-1:0] txt;
	logic [4:0] spos;
	logic rd_pending;
	logic f_in_ready;
	logic f_valid;
	logic [6:0] f_data;
	logic [VAL_IDX_W-1:0] trim_len;

	function automatic logic [6:0] hex_char(input logic [3:0] v);
		return (v < 4'hA) ? (CH_ZERO + 7'(v)) : (7'h37 + 7'(v));
	endfunction

	function automatic logic [6:0] char_at(input logic [VAL_W*7-1:0] t,
			input logic [VAL_IDX_W-1:0] i);
		return t[7*i +: 7];
	endfunction

	// Drops trailing fractional zeros and a bare decimal point.
	always_comb begin // [RULE_05]
		logic has_dot;
		has_dot = 1'b0;
		trim_len = prm_len;
		for (int i = 0; i < VAL_W; i++) begin
			if (VAL_IDX_W'(i) < prm_len && char_at(prm_text, VAL_IDX_W'(i)) == CH_DOT) begin
				has_dot = 1'b1;
			end
		end
		if (has_dot) begin
			for (int i = 0; i < VAL_W; i++) begin
				if (trim_len != '0 && char_at(prm_text, trim_len - 1'b1) == CH_ZERO) begin
					trim_len = trim_len - 1'b1;
				end
			end
			if (trim_len != '0 && char_at(prm_text, trim_len - 1'b1) == CH_DOT) begin
				trim_len = trim_len - 1'b1;
			end
		end
	end

	wire logic addr_ok = (abuf[0] == abuf[1]) && (abuf[2] == abuf[3]) && // [RULE_03]
		(abuf[0] == hex_char({1'b0, group_address_digit})) && // [RULE_23]
		(abuf[2] == hex_char(unit_address_digit));
	wire logic rx_eot = rx_valid && rx_char.data == CH_EOT;
	wire logic rx_bad = rx_valid && rx_char.parity_err; // [RULE_20] [RULE_21] [RULE_22]

	assign connected = (st == ST_WAIT);

	// ----------------------------------------
	// Protocol sequencer
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= ST_IDLE;
			acnt <= '0;
			for (int i = 0; i < ADDR_CHARS; i++) begin
				abuf[i] <= '0;
			end
			prm_code <= '0;
			prm_rd_req <= 1'b0;
			prm_next_req <= 1'b0;
			prm_wr_req <= 1'b0;
			prm_wr_text <= '0;
			prm_wr_len <= '0;
			tlen <= '0;
			txt <= '0;
			rbcc <= '0;
			spos <= '0;
			rd_pending <= 1'b0;
		end else if (ce) begin
			prm_rd_req <= 1'b0;
			prm_next_req <= 1'b0;
			prm_wr_req <= 1'b0;
			if (rx_eot) begin // [RULE_01]
				st <= ST_ADDR;
				acnt <= '0;
			end else begin
				unique case (st)
					ST_IDLE, ST_DEAF: begin
						st <= st; // [RULE_24]
					end
					ST_ADDR: begin
						if (rx_valid) begin
							abuf[acnt[1:0]] <= rx_char.data;
							acnt <= acnt + 3'h1;
							if (rx_bad) begin
								st <= ST_DEAF; // [RULE_12]
							end else if (acnt == 3'(ADDR_CHARS - 1)) begin
								st <= ST_CMD;
							end
						end
					end
					ST_CMD: begin
						if (!addr_ok || !serial_link_enable) begin
							st <= ST_DEAF; // [RULE_12] [RULE_19] [RULE_24]
						end else if (rx_valid) begin
							if (rx_bad) begin
								st <= ST_DEAF;
							end else if (rx_char.data == CH_STX) begin
								st <= ST_WCODE1; // [RULE_14]
								rbcc <= '0;
							end else begin
								prm_code.code_hi <= rx_char.data; // [RULE_02]
								st <= ST_CODE2;
							end
						end
					end
					ST_CODE2: begin
						if (rx_valid) begin
							prm_code.code_lo <= rx_char.data;
							st <= rx_bad ? ST_DEAF : ST_ENQ;
						end
					end
					ST_ENQ: begin
						if (rx_valid) begin
							if (rx_bad || rx_char.data != CH_ENQ) begin
								st <= ST_DEAF; // [RULE_12]
							end else begin
								prm_rd_req <= 1'b1;
								rd_pending <= 1'b1;
								st <= ST_LOOK;
							end
						end
					end
					ST_LOOK: begin
						// The lookup answers one cycle after the request.
						if (!prm_rd_req && !prm_next_req) begin
							txt <= prm_text;
							tlen <= trim_len;
							spos <= '0;
							rd_pending <= prm_known;
							st <= ST_SEND;
						end
					end
					ST_SEND: begin
						if (f_in_ready && (!rd_pending || spos == 5'(tlen) + 5'h4)) begin
							st <= rd_pending ? ST_WAIT : ST_IDLE; // [RULE_08] [RULE_25]
						end
						if (f_in_ready) begin
							spos <= spos + 5'h1;
						end
					end
					ST_WAIT: begin
						if (rx_valid && !rx_bad) begin
							if (rx_char.data == CH_NAK) begin
								spos <= '0; // [RULE_09]
								st <= ST_SEND;
							end else if (rx_char.data == CH_ACK) begin
								prm_code <= prm_next_code; // [RULE_10]
								prm_next_req <= 1'b1;
								st <= ST_LOOK;
							end else if (rx_char.data == CH_STX) begin
								st <= ST_WCODE1; // [RULE_18]
								rbcc <= '0;
							end
						end
					end
					ST_WCODE1: begin
						if (rx_valid) begin
							prm_code.code_hi <= rx_char.data;
							rbcc <= rbcc ^ rx_char.data; // [RULE_06]
							st <= rx_bad ? ST_DEAF : ST_WCODE2;
						end
					end
					ST_WCODE2: begin
						if (rx_valid) begin
							prm_code.code_lo <= rx_char.data;
							rbcc <= rbcc ^ rx_char.data;
							prm_wr_len <= '0;
							prm_wr_text <= '0;
							st <= rx_bad ? ST_DEAF : ST_WDATA;
						end
					end
					ST_WDATA: begin
						if (rx_valid) begin
							rbcc <= rbcc ^ rx_char.data;
							if (rx_bad) begin
								st <= ST_DEAF; // [RULE_19]
							end else if (rx_char.data == CH_ETX) begin
								st <= ST_WBCC;
							end else if (prm_wr_len != VAL_IDX_W'(VAL_W)) begin
								prm_wr_text[7*prm_wr_len +: 7] <= rx_char.data;
								prm_wr_len <= prm_wr_len + 1'b1;
							end
						end
					end
					ST_WBCC: begin
						if (rx_valid) begin
							if (rx_bad) begin
								st <= ST_DEAF; // [RULE_19]
							end else begin
								rd_pending <= (rx_char.data == rbcc); // [RULE_16]
								prm_wr_req <= (rx_char.data == rbcc);
								st <= ST_WCHK;
							end
						end
					end
					ST_WCHK: begin
						if (!prm_wr_req && f_in_ready) begin
							rd_pending <= 1'b0;
							st <= ST_WAIT; // [RULE_18]
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Reply composition
	// ----------------------------------------
	logic [VAL_IDX_W-1:0] vi;
	always_comb begin
		vi = VAL_IDX_W'(spos - 5'h3);
		f_data = CH_EOT;
		if (st == ST_WCHK) begin
			f_data = (rd_pending && prm_wr_ok) ? CH_ACK : CH_NAK; // [RULE_16] [RULE_17]
		end else if (!rd_pending) begin
			f_data = CH_EOT; // [RULE_08]
		end else if (spos == 5'h0) begin
			f_data = CH_STX; // [RULE_04]
		end else if (spos == 5'h1) begin
			f_data = prm_code.code_hi;
		end else if (spos == 5'h2) begin
			f_data = prm_code.code_lo;
		end else if (spos < 5'(tlen) + 5'h3) begin
			f_data = char_at(txt, vi);
		end else if (spos == 5'(tlen) + 5'h3) begin
			f_data = CH_ETX;
		end else begin
			f_data = bcc; // [RULE_06]
		end
	end

	assign f_valid = (st == ST_WCHK && !prm_wr_req) ||
		(st == ST_SEND && (rd_pending || spos == 5'h0));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bcc <= '0;
		end else if (ce && st == ST_SEND && f_in_ready) begin
			if (spos == 5'h0) begin
				bcc <= '0;
			end else if (spos < 5'(tlen) + 5'h4) begin
				bcc <= bcc ^ f_data; // [RULE_06]
			end
		end
	end

	spl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_txq (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.in_valid(f_valid),
		.in_ready(f_in_ready),
		.in_data(f_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_eot_resets: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
		ce && rx_eot |=> st == ST_ADDR)
		else $error("EOT did not restart addressing.");
	a_deaf_quiet: assert property (@(posedge clk) disable iff (rst) // [RULE_24]
		st == ST_DEAF |-> !f_valid)
		else $error("Unmatched slave queued a character.");
	a_disabled_silent: assert property (@(posedge clk) disable iff (rst) // [RULE_12]
		ce && st == ST_CMD && !serial_link_enable && !rx_eot |=> st == ST_DEAF)
		else $error("Disabled link did not go silent.");
	a_stx_first: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
		st == ST_SEND && rd_pending && spos == 5'h0 |-> f_data == CH_STX)
		else $error("Reply did not open with STX.");
	a_etx_before_bcc: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
		st == ST_SEND && rd_pending && spos == 5'(tlen) + 5'h3 |-> f_data == CH_ETX)
		else $error("Reply value not closed by ETX.");
	a_unknown_eot: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
		st == ST_SEND && !rd_pending |-> f_valid && f_data == CH_EOT)
		else $error("Unknown code not answered by EOT.");
	a_nak_repeat: assert property (@(posedge clk) disable iff (rst) // [RULE_09]
		ce && st == ST_WAIT && rx_valid && !rx_bad && rx_char.data == CH_NAK && !rx_eot
		|=> st == ST_SEND && spos == 5'h0)
		else $error("NAK did not restart the reply.");
	a_ack_next: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
		ce && st == ST_WAIT && rx_valid && !rx_bad && rx_char.data == CH_ACK && !rx_eot
		|=> prm_next_req && st == ST_LOOK)
		else $error("ACK did not advance the list.");
	a_write_answer: assert property (@(posedge clk) disable iff (rst) // [RULE_17]
		st == ST_WCHK && !prm_wr_req && !(rd_pending && prm_wr_ok) |-> f_data == CH_NAK)
		else $error("Failed write not answered by NAK.");
endmodule

// >>> tb/serial_parameter_link_slave_tb_top.sv
// Self-checking testbench of the serial parameter link slave.
`timescale 1ns/100ps
module serial_parameter_link_slave_tb_top;
	import spl_pkg::*;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ena = 1'b1;
	logic [2:0] own_g = 3'h0;
	logic [3:0] own_u = 4'h0;
	logic rx_valid;
	spl_rx_char_s rx_char;
	spl_code_s prm_code;
	spl_code_s prm_next_code;
	logic prm_known;
	logic [VAL_MAX*7-1:0] prm_text;
	logic [VAL_MAX*7-1:0] prm_wr_text;
	logic [VAL_IDX_W-1:0] prm_len;
	logic prm_wr_ok;
	logic tx_valid;
	logic tx_ready;
	logic [6:0] tx_data;
	logic connected;
	logic [6:0] exp_q[$];
	int error_cnt = 0;
	int cmp_count = 0;
	int rd_cnt = 0;
	int nx_cnt = 0;
	int wr_cnt = 0;
	logic [6:0] exp_wr_len = 7'h00;
	logic rd_req;
	logic nx_req;
	logic wr_req;
	logic [VAL_IDX_W-1:0] wr_len;

	always #4 clk = ~clk;

	spl_slave dut (
		.clk(clk),
		.rst(rst),
		.ce(1'b1),
		.serial_link_enable(ena),
		.group_address_digit(own_g),
		.unit_address_digit(own_u),
		.rx_valid(rx_valid),
		.rx_char(rx_char),
		.prm_code(prm_code),
		.prm_rd_req(rd_req),
		.prm_next_req(nx_req),
		.prm_known(prm_known),
		.prm_text(prm_text),
		.prm_len(prm_len),
		.prm_next_code(prm_next_code),
		.prm_wr_req(wr_req),
		.prm_wr_text(prm_wr_text),
		.prm_wr_len(wr_len),
		.prm_wr_ok(prm_wr_ok),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.tx_data(tx_data),
		.connected(connected)
	);

	spl_host_model host (
		.clk(clk),
		.rx_valid(rx_valid),
		.rx_char(rx_char),
		.tx_ready(tx_ready)
	);

	// ----------------------------------------
	// Parameter table: code 10 holds 1.50, code 11 holds 7.00.
	// ----------------------------------------
	always_comb begin
		prm_known = 1'b0;
		prm_text = '0;
		prm_len = 4'h0;
		if (prm_code == {7'h31, 7'h30}) begin
			prm_known = 1'b1;
			prm_text[27:0] = {7'h30, 7'h35, 7'h2E, 7'h31};
			prm_len = 4'h4;
		end else if (prm_code == {7'h31, 7'h31}) begin
			prm_known = 1'b1;
			prm_text[27:0] = {7'h30, 7'h30, 7'h2E, 7'h37};
			prm_len = 4'h4;
		end
	end
	assign prm_next_code = (prm_code == {7'h31, 7'h30}) ? {7'h31, 7'h31} : {7'h31, 7'h30};
	// Only code 10 is writable, and a value starting with 9 is out of range.
	assign prm_wr_ok = (prm_code == {7'h31, 7'h30}) && (prm_wr_text[6:0] != 7'h39);

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (exp_q.size() == 0) check("tx_silent", 7'h01, 7'h00);
			else check("tx_data", tx_data, exp_q.pop_front());
		end
		if (rd_req === 1'b1) rd_cnt++;
		if (nx_req === 1'b1) nx_cnt++;
		if (wr_req === 1'b1) begin
			wr_cnt++;
			check("prm_wr_len", 7'(wr_len), exp_wr_len);
		end
	end

	task automatic expect_reply(input logic [6:0] c1, input logic [6:0] c2,
			input logic [6:0] v[$]);
		logic [6:0] bcc;
		bcc = c1 ^ c2 ^ CH_ETX;
		exp_q.push_back(CH_STX);
		exp_q.push_back(c1);
		exp_q.push_back(c2);
		foreach (v[i]) begin
			exp_q.push_back(v[i]);
			bcc ^= v[i];
		end
		exp_q.push_back(CH_ETX);
		exp_q.push_back(bcc);
	endtask

	task automatic settle();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check("pending_chars", 7'(exp_q.size()), 7'h00);
		repeat (40) @(posedge clk);
		#1;
	endtask

	task automatic conclude();
		if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#400000;
		error_cnt++;
		conclude();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(25668));
		own_g = 3'($urandom % 8);
		own_u = 4'($urandom % 16);
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		expect_reply(7'h31, 7'h30, '{7'h31, 7'h2E, 7'h35});
		host.poll(own_g, own_u, 7'h31, 7'h30, -1);
		settle();
		check("connected", {6'h00, connected}, 7'h01);
		expect_reply(7'h31, 7'h30, '{7'h31, 7'h2E, 7'h35});
		host.send_char(CH_NAK, 1'b0);
		settle();
		expect_reply(7'h31, 7'h31, '{7'h37});
		host.send_char(CH_ACK, 1'b0);
		settle();
		exp_q.push_back(CH_EOT);
		host.poll(own_g, own_u, 7'h5A, 7'h5A, -1);
		settle();
		host.poll(own_g, own_u + 4'h1, 7'h31, 7'h30, -1);
		host.send_char(CH_NAK, 1'b0);
		settle();
		check("connected", {6'h00, connected}, 7'h00);
		host.poll(own_g, own_u, 7'h31, 7'h30, 7);
		settle();
		ena = 1'b0;
		host.poll(own_g, own_u, 7'h31, 7'h30, -1);
		host.select(own_g, own_u, 1'b1, 7'h31, 7'h30, '{7'h32}, 7'h00, -1);
		settle();
		ena = 1'b1;
		exp_wr_len = 7'h03;
		exp_q.push_back(CH_ACK);
		host.select(own_g, own_u, 1'b1, 7'h31, 7'h30, '{7'h32, 7'h2E, 7'h35}, 7'h00, -1);
		settle();
		exp_q.push_back(CH_NAK);
		exp_wr_len = 7'h01;
		host.select(own_g, own_u, 1'b1, 7'h31, 7'h30, '{7'h39}, 7'h00, -1);
		settle();
		exp_q.push_back(CH_NAK);
		host.select(own_g, own_u, 1'b1, 7'h31, 7'h31, '{7'h33}, 7'h00, -1);
		settle();
		exp_q.push_back(CH_NAK);
		host.select(own_g, own_u, 1'b1, 7'h31, 7'h30, '{7'h34}, 7'h01, -1);
		settle();
		exp_q.push_back(CH_ACK);
		host.select(own_g, own_u, 1'b0, 7'h31, 7'h30, '{7'h34}, 7'h00, -1);
		settle();
		host.select(own_g, own_u, 1'b1, 7'h31, 7'h30, '{7'h34}, 7'h00, 9);
		host.select(own_g + 3'h1, own_u, 1'b1, 7'h31, 7'h30, '{7'h34}, 7'h00, -1);
		settle();
		for (int i = 0; i < 6; i++) begin
			own_g = 3'($urandom % 8);
			own_u = 4'($urandom % 16);
			expect_reply(7'h31, 7'h30, '{7'h31, 7'h2E, 7'h35});
			host.poll(own_g, own_u, 7'h31, 7'h30, -1);
			settle();
		end
		// A reset in mid-session drops the connection and empties the reply queue.
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("connected", {6'h00, connected}, 7'h00);
		check("tx_valid", {6'h00, tx_valid}, 7'h00);
		rst = 1'b0;
		expect_reply(7'h31, 7'h30, '{7'h31, 7'h2E, 7'h35});
		host.poll(own_g, own_u, 7'h31, 7'h30, -1);
		settle();
		check("rd_req_count", 7'(rd_cnt), 7'h09);
		check("next_req_count", 7'(nx_cnt), 7'h01);
		check("wr_req_count", 7'(wr_cnt), 7'h04);
		conclude();
	end
endmodule

// >>> tb/spl_host_model.sv
// Link master model that sends request characters and drains the slave's replies.
`timescale 1ns/100ps
module spl_host_model (
	input wire logic clk, // Clock.
	output logic rx_valid, // Character strobe toward the slave.
	output spl_pkg::spl_rx_char_s rx_char, // Character and parity flag.
	output logic tx_ready // Master accepts a reply character.
);
	import spl_pkg::*;

	initial begin
		rx_valid = 1'b0;
		rx_char = '0;
		tx_ready = 1'b0;
	end

	// ----------------------------------------
	// Reply side
	// ----------------------------------------
	// Random stalls let the reply queue fill behind a slow master.
	always @(posedge clk) begin
		#1;
		tx_ready <= ($urandom % 4) != 0;
	end

	// ----------------------------------------
	// Request side
	// ----------------------------------------
	function automatic logic [6:0] hexc(input logic [3:0] v);
		return (v < 4'hA) ? 7'h30 + 7'(v) : 7'h37 + 7'(v);
	endfunction

	// An idle character line shows the inverse of the last value, never a stale copy.
	task automatic send_char(input logic [6:0] ch, input logic perr);
		@(posedge clk);
		#1;
		rx_valid = 1'b1;
		rx_char = '{data: ch, parity_err: perr};
		@(posedge clk);
		#1;
		rx_valid = 1'b0;
		rx_char = '{data: ~ch, parity_err: ~perr};
	endtask

	task automatic send_q(input logic [6:0] q[$], input int bad_at);
		foreach (q[i]) send_char(q[i], i == bad_at);
	endtask

	task automatic poll(input logic [2:0] g, input logic [3:0] u, input logic [6:0] c1,
			input logic [6:0] c2, input int bad_at);
		send_q('{CH_EOT, hexc({1'b0, g}), hexc({1'b0, g}), hexc(u), hexc(u), c1, c2, CH_ENQ},
			bad_at);
	endtask

	task automatic select(input logic [2:0] g, input logic [3:0] u, input bit addr,
			input logic [6:0] c1, input logic [6:0] c2, input logic [6:0] v[$],
			input logic [6:0] bcc_err, input int bad_at);
		logic [6:0] q[$];
		logic [6:0] bcc;
		if (addr) begin
			q = '{CH_EOT, hexc({1'b0, g}), hexc({1'b0, g}), hexc(u), hexc(u)};
		end
		q.push_back(CH_STX);
		q.push_back(c1);
		q.push_back(c2);
		foreach (v[i]) q.push_back(v[i]);
		q.push_back(CH_ETX);
		bcc = c1 ^ c2 ^ CH_ETX;
		foreach (v[i]) bcc ^= v[i];
		q.push_back(bcc ^ bcc_err);
		send_q(q, bad_at);
	endtask
endmodule
